// ==== src/four_way_write_through_cache.sv ====
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "cache_params.svh"

module four_way_write_through_cache
(
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic [31:0]             paddr,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [31:0]             pwdata,
  output var  logic [31:0]             prdata,
  output var  logic                    pready,
  output var  logic                    pslverr,
  input  wire logic                    cpu_req_valid,
  input  wire cache_pkg::cpu_req_type  cpu_req,
  output var  logic                    cpu_busy,
  output var  logic                    cpu_done,
  output var  logic [31:0]             cpu_rdata,
  output var  logic                    ibus_valid,
  output var  cache_pkg::ibus_cmd_type ibus_cmd,
  input  wire logic                    ibus_ack,
  input  wire logic [31:0]             ibus_rdata
);

  // ****************************************************************
  // Storage and control state
  // ****************************************************************
  logic [7:0]                 cache_setup_reg;
  cache_pkg::cache_state_type state;
  cache_pkg::cpu_req_type     held;
  logic [1:0]                 beat;
  logic [1:0]                 fill_way;
  logic [3:0]                 purge_mask;
  logic [31:0]                fill_last;
  // The arrays are not cleared by reset; software purges before enabling.
  logic [18:0]                tag_mem   [4][64];
  logic [63:0]                valid_bits[4];
  logic [5:0]                 lru_bits  [64];
  logic [31:0]                data_mem  [4][256];

  logic        cache_enable;
  logic        data_fill_inhibit;
  logic        instr_fill_inhibit;
  logic        half_ram_mode;
  logic [1:0]  way_select;
  logic        reg_hit;
  logic        purge_all_bit;
  logic [5:0]  idx;
  logic [18:0] tag_in;
  logic [2:0]  part;
  logic        accept;
  logic        cached;
  logic        cached_rd;
  logic        cached_wr;
  logic        allocate;
  logic        is_purge;
  logic        is_aa;
  logic        is_da;
  logic [3:0]  hit_vec;
  logic        hit_any;
  logic [1:0]  hit_way;
  logic [1:0]  victim;
  logic [1:0]  da_way;
  logic [31:0] aa_word;

  assign cache_enable       = cache_setup_reg[`BIT_CACHE_ENABLE];
  assign data_fill_inhibit  = cache_setup_reg[`BIT_DATA_FILL_INHIBIT];
  assign instr_fill_inhibit = cache_setup_reg[`BIT_INSTR_FILL_INHIBIT];
  assign half_ram_mode      = cache_setup_reg[`BIT_HALF_RAM_MODE];
  assign way_select         = {cache_setup_reg[`BIT_WAY_SELECT_HIGH], cache_setup_reg[`BIT_WAY_SELECT_LOW]};

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  function automatic logic [31:0] extract(input logic [31:0] word, input logic [1:0] off, input logic [1:0] size);
    logic [31:0] r;
    r = word;
    if (size == `SIZE_BYTE)
    begin
      r = {24'h000000, word[(5'd24 - {off, 3'b000}) +: 8]};
    end
    else if (size == `SIZE_WORD)
    begin
      r = off[1] ? {16'h0000, word[15:0]} : {16'h0000, word[31:16]};
    end
    return r;
  endfunction

  function automatic logic [31:0] lanes(input logic [31:0] data, input logic [1:0] size);
    logic [31:0] r;
    r = data;
    if (size == `SIZE_BYTE)
    begin
      r = {4{data[7:0]}};
    end
    else if (size == `SIZE_WORD)
    begin
      r = {2{data[15:0]}};
    end
    return r;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input cache_pkg::cpu_req_type req);
    logic [3:0]  m;
    logic [31:0] bm;
    m = 4'hF;
    if (req.size == `SIZE_BYTE)
    begin
      m = 4'h8 >> req.addr[1:0];
    end
    else if (req.size == `SIZE_WORD)
    begin
      m = req.addr[1] ? 4'h3 : 4'hC;
    end
    bm = {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
    return (old & ~bm) | (lanes(req.wdata, req.size) & bm);
  endfunction

  function automatic logic [5:0] lru_next(input logic [5:0] l, input logic [1:0] way);
    logic [5:0] r;
    r = l;
    unique case (way)
      2'h0: r[5:3] = 3'h0;
      2'h1:
      begin
        r[5]   = 1'b1;
        r[2:1] = 2'h0;
      end
      2'h2:
      begin
        r[4] = 1'b1;
        r[2] = 1'b1;
        r[0] = 1'b0;
      end
      2'h3:
      begin
        r[3] = 1'b1;
        r[1] = 1'b1;
        r[0] = 1'b1;
      end
    endcase
    return r;
  endfunction

  // An illegal pattern falls through to way 3, so a bad LRU value still picks a way.
  function automatic logic [1:0] pick_victim(input logic [5:0] l, input logic half);
    logic [1:0] r;
    r = 2'h3;
    if (half)
    begin
      r = l[0] ? 2'h2 : 2'h3;
    end
    else if (l[5] && l[4] && l[3])
    begin
      r = 2'h0;
    end
    else if (!l[5] && l[2] && l[1])
    begin
      r = 2'h1;
    end
    else if (!l[4] && !l[2] && l[0])
    begin
      r = 2'h2;
    end
    return r;
  endfunction

  // ****************************************************************
  // Request decode and tag compare
  // ****************************************************************
  assign idx       = cpu_req.addr[9:4];
  assign tag_in    = cpu_req.addr[28:10];
  assign part      = cpu_req.addr[31:29];
  assign accept    = cpu_req_valid && !cpu_busy && state == cache_pkg::st_idle;
  assign cached    = cpu_req.addr[31:28] == `PART_CACHE && cache_enable;
  assign cached_rd = cached && !cpu_req.write;
  assign cached_wr = cached && cpu_req.write;
  assign allocate  = cpu_req.ifetch ? !instr_fill_inhibit : !data_fill_inhibit;
  assign is_purge  = part == `PART_ASSOC_PURGE;
  assign is_aa     = part == `PART_ADDR_ARRAY;
  assign is_da     = part == `PART_DATA_ARRAY;
  assign da_way    = cpu_req.addr[11:10];
  assign hit_any   = |hit_vec;
  assign victim    = pick_victim(lru_bits[idx], half_ram_mode);
  assign aa_word   = {3'h0, tag_mem[way_select][idx], lru_bits[idx], 1'b0, valid_bits[way_select][idx], 2'h0};

  genvar w;
  generate
    for (w = 0; w < 4; w++)
    begin : g_compare
      assign hit_vec[w] = valid_bits[w][idx] && tag_mem[w][idx] == tag_in;
    end
  endgenerate

  always_comb
  begin
    hit_way = 2'h0;
    for (int i = 3; i >= 0; i--)
    begin
      if (hit_vec[i])
      begin
        hit_way = 2'(i);
      end
    end
  end

  // ****************************************************************
  // Setup register on APB
  // ****************************************************************
  assign reg_hit       = paddr == `SETUP_REG_OFFSET;
  assign purge_all_bit = psel && penable && pready && pwrite && reg_hit && pwdata[`BIT_PURGE_ALL];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cache_setup_reg <= `SETUP_RESET;
      pready          <= 1'b0;
      pslverr         <= 1'b0;
      prdata          <= 32'h00000000;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !reg_hit;
      prdata  <= (psel && !penable && reg_hit) ? {24'h000000, cache_setup_reg} : 32'h00000000;
      if (psel && penable && pready && pwrite && reg_hit)
      begin
        cache_setup_reg <= pwdata[7:0] & `SETUP_WRITE_MASK;
      end
    end
  end

  // ****************************************************************
  // Sequencer, processor answer and internal bus master
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state      <= cache_pkg::st_idle;
      cpu_busy   <= 1'b0;
      cpu_done   <= 1'b0;
      cpu_rdata  <= 32'h00000000;
      ibus_valid <= 1'b0;
      ibus_cmd   <= '0;
      held       <= '0;
      beat       <= 2'h0;
      fill_way   <= 2'h0;
      purge_mask <= 4'h0;
      fill_last  <= 32'h00000000;
    end
    else
    begin
      cpu_done <= 1'b0;
      unique case (state)
        cache_pkg::st_idle:
        begin
          if (accept)
          begin
            held <= cpu_req;
            if (cached_rd && hit_any)
            begin
              cpu_done  <= 1'b1;
              cpu_rdata <= extract(data_mem[hit_way][cpu_req.addr[9:2]], cpu_req.addr[1:0], cpu_req.size);
            end
            else if (cached_rd && allocate)
            begin
              cpu_busy   <= 1'b1;
              ibus_valid <= 1'b1;
              ibus_cmd   <= '{addr: {cpu_req.addr[31:4], cpu_req.addr[3:2] + 2'h1, 2'h0}, write: 1'b0,
                              size: `SIZE_LONG, wdata: 32'h00000000};
              beat       <= 2'h0;
              fill_way   <= victim;
              state      <= cache_pkg::st_fill;
            end
            else if (is_purge)
            begin
              cpu_busy   <= 1'b1;
              purge_mask <= hit_vec;
              state      <= cache_pkg::st_purge;
            end
            else if (is_aa)
            begin
              cpu_done  <= 1'b1;
              cpu_rdata <= (cpu_req.write || cpu_req.size != `SIZE_LONG) ? 32'h00000000 : aa_word;
            end
            else if (is_da && cpu_req.write)
            begin
              cpu_busy <= 1'b1;
              state    <= cache_pkg::st_da_write;
            end
            else if (is_da)
            begin
              cpu_done  <= 1'b1;
              cpu_rdata <= extract(data_mem[da_way][cpu_req.addr[9:2]], cpu_req.addr[1:0], cpu_req.size);
            end
            else
            begin
              // Uncached, through, inhibited misses and writes all go outside one cycle later.
              cpu_busy   <= 1'b1;
              ibus_valid <= 1'b1;
              ibus_cmd   <= '{addr: cpu_req.addr, write: cpu_req.write, size: cpu_req.size,
                              wdata: cpu_req.write ? lanes(cpu_req.wdata, cpu_req.size) : 32'h00000000};
              state      <= cpu_req.write ? cache_pkg::st_ext_write : cache_pkg::st_ext_read;
            end
          end
        end
        cache_pkg::st_fill:
        begin
          if (ibus_ack)
          begin
            beat <= beat + 2'h1;
            if (beat == `FILL_LAST_BEAT)
            begin
              ibus_valid <= 1'b0;
              fill_last  <= ibus_rdata;
              state      <= cache_pkg::st_fill_done;
            end
            else
            begin
              ibus_cmd.addr[3:2] <= ibus_cmd.addr[3:2] + 2'h1;
            end
          end
        end
        cache_pkg::st_fill_done:
        begin
          cpu_done  <= 1'b1;
          cpu_rdata <= extract(fill_last, held.addr[1:0], held.size);
          cpu_busy  <= 1'b0;
          state     <= cache_pkg::st_idle;
        end
        cache_pkg::st_ext_read:
        begin
          if (ibus_ack)
          begin
            ibus_valid <= 1'b0;
            cpu_done   <= 1'b1;
            cpu_rdata  <= extract(ibus_rdata, held.addr[1:0], held.size);
            cpu_busy   <= 1'b0;
            state      <= cache_pkg::st_idle;
          end
        end
        cache_pkg::st_ext_write:
        begin
          if (ibus_ack)
          begin
            ibus_valid <= 1'b0;
            cpu_done   <= 1'b1;
            cpu_busy   <= 1'b0;
            state      <= cache_pkg::st_idle;
          end
        end
        cache_pkg::st_purge, cache_pkg::st_da_write:
        begin
          cpu_done <= 1'b1;
          cpu_busy <= 1'b0;
          state    <= cache_pkg::st_idle;
        end
      endcase
    end
  end

  // ****************************************************************
  // Tag and valid array
  // ****************************************************************
  // Tag and valid are written as the fill starts, so a fill cut short leaves a stale line.
  always_ff @(posedge pclk)
  begin
    if (purge_all_bit)
    begin
      for (int i = 0; i < 4; i++)
      begin
        valid_bits[i] <= 64'h0000000000000000;
      end
    end
    if (state == cache_pkg::st_purge)
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (purge_mask[i])
        begin
          valid_bits[i][held.addr[9:4]] <= 1'b0;
        end
      end
    end
    else if (accept && cached_rd && !hit_any && allocate)
    begin
      tag_mem[victim][idx]    <= tag_in;
      valid_bits[victim][idx] <= 1'b1;
    end
    else if (accept && is_aa && cpu_req.write && cpu_req.size == `SIZE_LONG)
    begin
      tag_mem[way_select][idx]    <= tag_in;
      valid_bits[way_select][idx] <= cpu_req.addr[`AA_VALID_BIT];
    end
  end

  // ****************************************************************
  // LRU array
  // ****************************************************************
  always_ff @(posedge pclk)
  begin
    if (purge_all_bit)
    begin
      for (int i = 0; i < 64; i++)
      begin
        lru_bits[i] <= 6'h00;
      end
    end
    else if (accept && cached && hit_any)
    begin
      lru_bits[idx] <= lru_next(lru_bits[idx], hit_way);
    end
    else if (accept && cached_rd && allocate)
    begin
      lru_bits[idx] <= lru_next(lru_bits[idx], victim);
    end
    else if (accept && is_aa && cpu_req.write && cpu_req.size == `SIZE_LONG)
    begin
      lru_bits[idx] <= cpu_req.wdata[`AA_LRU_LSB +: 6];
    end
  end

  // ****************************************************************
  // Data array
  // ****************************************************************
  always_ff @(posedge pclk)
  begin
    if (state == cache_pkg::st_fill && ibus_ack)
    begin
      data_mem[fill_way][ibus_cmd.addr[9:2]] <= ibus_rdata;
    end
    else if (accept && cached_wr && hit_any)
    begin
      data_mem[hit_way][cpu_req.addr[9:2]] <= merge(data_mem[hit_way][cpu_req.addr[9:2]], cpu_req);
    end
    else if (accept && is_da && cpu_req.write)
    begin
      data_mem[da_way][cpu_req.addr[9:2]] <= merge(data_mem[da_way][cpu_req.addr[9:2]], cpu_req);
    end
  end

endmodule // four_way_write_through_cache

`default_nettype wire

// ==== src/cache_params.svh ====
// Behaviour
// - Address bits 31..29 select through, purge, array windows; the cached window also needs bit 28 zero.
// - Bits 9..4 pick one of 64 entries; valid matching tag in any way hits.
// - Read hit returns sized data one cycle later; hits accepted every cycle.
// - Read miss with allocation writes tag to LRU victim way and sets valid.
// - Fill reads four longwords, offset stepping by four, requested longword last.
// - Missed read data reaches the processor one cycle after the last fill write.
// - Every write outside the purge and array windows goes outside; tag match updates the data array, mismatch allocates nothing.
// - Write appears on internal bus one cycle later; processor stalls until done.
// - Through reads fetch only the item; through writes never touch the data array.
// - Read hit, write hit or allocation rewrites the six LRU bits per entry.
// - Victim way is chosen from the LRU bit patterns per the fixed table.
// - After purge-all, replacement runs way 3, 2, 1, 0; the purge-all itself writes LRU zero.
// - With fill inhibit for the access kind, a miss fetches and forwards without allocating.
// - Half-RAM mode replaces only ways 2 and 3; software clears ways 0 and 1.
// - Tag and valid are written at fill start; software purges after an aborted fill.
// - Writing purge-all clears all LRU state and every valid bit not set by an allocation or address-array write in that same cycle.
// - Reset clears cache enable; software disables before or together with purge.
// - Access at address plus 4000_0000 invalidates that line in any way in two cycles.
// - Data-array window takes byte, word, longword; one cycle read, two cycle write.
// - Data-array window maps each way to its own one-kilobyte slice.
// - Address-array window is shared by all ways; way-select picks; longword only.
// - Address-array read gives tag, LRU, valid; write takes tag/valid from address, LRU from data.
// - Purge-all bit self-clears and always reads zero.
// - Way-select bits 7 and 6 encode ways 0 to 3 in binary.
// - Half-RAM mode makes ways 2 and 3 cache and ways 0 and 1 RAM.
// - Fill inhibit bits act only while cache is enabled; hits still served.
`ifndef CACHE_PARAMS_SVH
`define CACHE_PARAMS_SVH

// ****************************************************************
// Register map and fields
// ****************************************************************
`define SETUP_REG_OFFSET       32'h0000_0000
`define SETUP_RESET            8'h00
`define SETUP_WRITE_MASK       8'hCF
`define BIT_WAY_SELECT_HIGH    7
`define BIT_WAY_SELECT_LOW     6
`define BIT_PURGE_ALL          4
`define BIT_HALF_RAM_MODE      3
`define BIT_DATA_FILL_INHIBIT  2
`define BIT_INSTR_FILL_INHIBIT 1
`define BIT_CACHE_ENABLE       0

// ****************************************************************
// Address partitions and windows
// ****************************************************************
`define PART_CACHE             4'h0
`define PART_THROUGH           3'h1
`define PART_ASSOC_PURGE       3'h2
`define PART_ADDR_ARRAY        3'h3
`define PART_DATA_ARRAY        3'h6
`define AA_LRU_LSB             4
`define AA_VALID_BIT           2

// ****************************************************************
// Access sizes and fill
// ****************************************************************
`define SIZE_BYTE              2'h0
`define SIZE_WORD              2'h1
`define SIZE_LONG              2'h2
`define FILL_LAST_BEAT         2'h3

`endif

// ==== src/cache_pkg.sv ====
package cache_pkg;

  typedef struct packed {
    logic [31:0] addr;
    logic        write;
    logic [1:0]  size;
    logic [31:0] wdata;
    logic        ifetch;
  } cpu_req_type;

  typedef struct packed {
    logic [31:0] addr;
    logic        write;
    logic [1:0]  size;
    logic [31:0] wdata;
  } ibus_cmd_type;

  typedef enum logic [2:0] {
    st_idle,
    st_fill,
    st_fill_done,
    st_ext_read,
    st_ext_write,
    st_purge,
    st_da_write
  } cache_state_type;

endpackage

// ==== test/cache_monitor.sv ====
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Port checker
// ****************************************
module cache_monitor
(
  input wire logic                    pclk,
  input wire logic                    presetn,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic                    pready,
  input wire logic [31:0]             prdata,
  input wire logic                    cpu_req_valid,
  input wire cache_pkg::cpu_req_type  cpu_req,
  input wire logic                    cpu_busy,
  input wire logic                    cpu_done,
  input wire logic                    ibus_valid,
  input wire cache_pkg::ibus_cmd_type ibus_cmd,
  input wire logic                    ibus_ack
);
  // A request counts as taken only when the core is free to accept it.
  wire       taken = cpu_req_valid && !cpu_busy;
  wire [2:0] part  = cpu_req.addr[31:29];
  wire       rd    = ibus_valid && ibus_ack && !ibus_cmd.write;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_purge_zero;
    psel && penable && pready && !pwrite |-> prdata[5:4] == 2'h0;
  endproperty
  a_purge_zero: assert property (p_purge_zero) else $error("purge bit read back as one");
  property p_wr_issue;
    taken && cpu_req.write && !(part inside {3'h2, 3'h3, 3'h6})
    |=> ibus_valid && ibus_cmd.write && ibus_cmd.addr == $past(cpu_req.addr);
  endproperty
  a_wr_issue: assert property (p_wr_issue) else $error("write not passed on next cycle");
  property p_thru_rd;
    taken && !cpu_req.write && part == 3'h1
    |=> ibus_valid && !ibus_cmd.write && ibus_cmd.addr[31:2] == $past(cpu_req.addr[31:2]);
  endproperty
  a_thru_rd: assert property (p_thru_rd) else $error("through read not fetched");
  property p_fill_step;
    rd ##1 ibus_valid |-> ibus_cmd.addr[31:4] == $past(ibus_cmd.addr[31:4])
      && ibus_cmd.addr[3:2] == $past(ibus_cmd.addr[3:2]) + 2'h1;
  endproperty
  a_fill_step: assert property (p_fill_step) else $error("fill offset did not step by four");
  property p_ack_done;
    ibus_valid && ibus_ack |=> ibus_valid || cpu_done or cpu_busy ##1 cpu_done;
  endproperty
  a_ack_done: assert property (p_ack_done) else $error("completion not one cycle after last beat");
  property p_stall;
    ibus_valid |-> cpu_busy && !cpu_done;
  endproperty
  a_stall: assert property (p_stall) else $error("core not stalled during bus access");
  property p_da_read;
    taken && part == 3'h6 && !cpu_req.write |=> cpu_done && !ibus_valid;
  endproperty
  a_da_read: assert property (p_da_read) else $error("data array read not one cycle");
  property p_da_write;
    taken && part == 3'h6 && cpu_req.write |=> !cpu_done ##1 cpu_done;
  endproperty
  a_da_write: assert property (p_da_write) else $error("data array write not two cycles");
  property p_assoc;
    taken && part == 3'h2 |=> (!ibus_valid && !cpu_done) ##1 cpu_done;
  endproperty
  a_assoc: assert property (p_assoc) else $error("line purge not two cycles");
  property p_aa;
    taken && part == 3'h3 |=> cpu_done;
  endproperty
  a_aa: assert property (p_aa) else $error("address array access not one cycle");

  c_fill: cover property (rd ##1 ibus_valid);
  c_write: cover property (ibus_valid && ibus_ack && ibus_cmd.write);
  c_assoc: cover property (taken && part == 3'h2);
endmodule // cache_monitor

bind four_way_write_through_cache cache_monitor i_cache_monitor
(
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pready(pready), .prdata(prdata), .cpu_req_valid(cpu_req_valid), .cpu_req(cpu_req),
  .cpu_busy(cpu_busy), .cpu_done(cpu_done), .ibus_valid(ibus_valid),
  .ibus_cmd(ibus_cmd), .ibus_ack(ibus_ack)
);
`default_nettype wire

// ==== test/ibus_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Internal bus memory
// ****************************************
module ibus_model
(
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic [1:0]              lag,
  input  wire logic                    ibus_valid,
  input  wire cache_pkg::ibus_cmd_type ibus_cmd,
  output var  logic                    ibus_ack,
  output var  logic [31:0]             ibus_rdata
);
  logic [1:0]  cnt;
  logic [31:0] last;
  logic [31:0] wr_addr;
  int          n_acks;
  // Data is a fixed function of the word address, so no storage is kept.
  // Between answers the bus shows the inverse of the last word, never a stale copy.
  assign ibus_rdata = ibus_ack ? {ibus_cmd.addr[31:2], 2'h0} ^ 32'h5A5A_0000 : ~last;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ibus_ack <= 1'b0;
      cnt <= 2'h0;
      last <= 32'h0;
      wr_addr <= 32'h0;
      n_acks <= 0;
    end
    else
    begin
      ibus_ack <= ibus_valid && !ibus_ack && cnt >= lag;
      cnt <= ibus_ack ? 2'h0 : cnt + {1'b0, ibus_valid && cnt < lag};
      if (ibus_ack)
      begin
        last <= ibus_rdata;
        n_acks <= n_acks + 1;
        if (ibus_cmd.write)
          wr_addr <= ibus_cmd.addr;
      end
    end
  end
endmodule // ibus_model
`default_nettype wire

// ==== test/four_way_write_through_cache_test.sv ====
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Bench
// ****************************************
module four_way_write_through_cache_test;
  logic                    pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [31:0]             paddr, pwdata, prdata, cpu_rdata, ibus_rdata, r;
  logic                    cpu_req_valid, cpu_busy, cpu_done, ibus_valid, ibus_ack, e;
  logic [1:0]              lag;
  cache_pkg::cpu_req_type  cpu_req;
  cache_pkg::ibus_cmd_type ibus_cmd;
  int                      bad_count, n_tests, cycles, k;

  four_way_write_through_cache i_four_way_write_through_cache
  (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_req_valid(cpu_req_valid), .cpu_req(cpu_req), .cpu_busy(cpu_busy),
    .cpu_done(cpu_done), .cpu_rdata(cpu_rdata), .ibus_valid(ibus_valid),
    .ibus_cmd(ibus_cmd), .ibus_ack(ibus_ack), .ibus_rdata(ibus_rdata)
  );
  ibus_model i_ibus_model
  (
    .pclk(pclk), .presetn(presetn), .lag(lag), .ibus_valid(ibus_valid),
    .ibus_cmd(ibus_cmd), .ibus_ack(ibus_ack), .ibus_rdata(ibus_rdata)
  );

  function automatic logic [31:0] mem(input logic [31:0] a);
    return {a[31:2], 2'h0} ^ 32'h5A5A_0000;
  endfunction
  function automatic logic [31:0] beats();
    return 32'(i_ibus_model.n_acks - k);
  endfunction
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // The request is dropped at the taking edge so it can never be taken twice.
  task automatic cpu(input logic w, input logic [1:0] s, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    cpu_req <= '{addr: a, write: w, size: s, wdata: d, ifetch: 1'b0};
    cpu_req_valid <= 1'b1;
    @(posedge pclk);
    cpu_req_valid <= 1'b0;
    @(posedge pclk);
    while (cpu_done !== 1'b1) @(posedge pclk);
    r = cpu_rdata;
  endtask
  task automatic scen_fill();
    @(posedge pclk) lag <= 2'h2;
    k = i_ibus_model.n_acks;
    cpu(1'b0, 2'h2, 32'h0000_0104, 32'h0);
    check("fill_data", r, mem(32'h0000_0104));
    check("fill_beats", beats(), 32'h4);
    cpu(1'b0, 2'h2, 32'h6000_0100, 32'h0);
    check("victim_entry", r, 32'h0000_00B4);
  endtask
  task automatic scen_write();
    @(posedge pclk) lag <= 2'h1;
    k = i_ibus_model.n_acks;
    cpu(1'b1, 2'h2, 32'h0000_0104, 32'h1234_5678);
    check("wr_addr", i_ibus_model.wr_addr, 32'h0000_0104);
    check("wr_beats", beats(), 32'h1);
    k = i_ibus_model.n_acks;
    cpu(1'b0, 2'h2, 32'h0000_0104, 32'h0);
    check("hit_data", r, 32'h1234_5678);
    check("hit_quiet", beats(), 32'h0);
  endtask
  task automatic scen_darray();
    cpu(1'b0, 2'h2, 32'hC000_0D04, 32'h0);
    check("da_read", r, 32'h1234_5678);
    cpu(1'b1, 2'h0, 32'hC000_0D04, 32'h0000_00AB);
    cpu(1'b0, 2'h2, 32'hC000_0D04, 32'h0);
    check("da_byte", r, 32'hAB34_5678);
    cpu(1'b0, 2'h0, 32'hC000_0D05, 32'h0);
    check("da_rd_byte", r, 32'h34);
  endtask
  task automatic scen_thru();
    k = i_ibus_model.n_acks;
    cpu(1'b0, 2'h2, 32'h2000_0104, 32'h0);
    check("thru_data", r, mem(32'h2000_0104));
    check("thru_beats", beats(), 32'h1);
  endtask
  task automatic scen_purge();
    cpu(1'b1, 2'h2, 32'h4000_0104, 32'h0);
    k = i_ibus_model.n_acks;
    cpu(1'b0, 2'h2, 32'h0000_0104, 32'h0);
    check("line_purged", beats(), 32'h4);
    apb(1'b1, 32'h0, 32'h11);
    k = i_ibus_model.n_acks;
    cpu(1'b0, 2'h2, 32'h0000_0104, 32'h0);
    check("all_purged", beats(), 32'h4);
  endtask
  task automatic scen_inhibit();
    apb(1'b1, 32'h0, 32'h05);
    cpu(1'b0, 2'h2, 32'h0000_0304, 32'h0);
    check("inh_data", r, mem(32'h0000_0304));
    k = i_ibus_model.n_acks;
    cpu(1'b0, 2'h2, 32'h0000_0304, 32'h0);
    check("inh_miss", beats(), 32'h1);
  endtask
  task automatic stop_test();
    if (bad_count == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      stop_test();
    end
  end
  initial
  begin
    {presetn, psel, penable, pwrite, cpu_req_valid, lag} = '0;
    {paddr, pwdata, cpu_req} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 32'h0, 32'h0);
    check("setup_reset", r, 32'h0);
    apb(1'b0, 32'h4, 32'h0);
    check("unmapped", {31'h0, e}, 32'h1);
    apb(1'b1, 32'h0, 32'hD1);
    apb(1'b0, 32'h0, 32'h0);
    check("setup_read", r, 32'hC1);
    scen_fill();
    scen_write();
    scen_darray();
    scen_thru();
    scen_purge();
    scen_inhibit();
    stop_test();
  end
endmodule // four_way_write_through_cache_test
`default_nettype wire
